// ===== gfx_power_state_and_sw_smi_regs.sv
`timescale 1ns/1ps
`default_nettype none

module gfx_power_state_and_sw_smi_regs
	import gfx_pm_pkg::*;
#(
	// return the graphics controller to initial values on D3 to D0
	parameter bit reinit_on_d0 = 1'b1
)
(
	// clock and reset
	input wire logic mclk,
	input wire logic sys_rst,
	// configuration access port
	input wire logic [7:0] cfg_addr,
	input wire logic cfg_wr,
	input wire logic cfg_rd,
	input wire logic [1:0] cfg_be,
	input wire logic [15:0] cfg_wdata,
	output logic [15:0] cfg_rdata,
	output logic cfg_ack,
	// power state to the graphics controller
	output logic [1:0] power_state,
	output logic graphics_reinit,
	// system management interrupt
	output logic smi_request,
	output logic smi_trigger,
	// mailbox contents for firmware
	output logic [6:0] software_flag,
	output logic [7:0] scratch_byte
);

	word_write_if mailbox_wr();

	logic [15:0] mailbox_value;
	logic mailbox_event;
	logic [1:0] requested_state;
	logic [1:0] next_power_state;
	logic control_hit;
	logic mailbox_hit;
	logic control_wr;
	logic state_supported;
	logic [15:0] control_view;
	logic [15:0] next_rdata;
	logic event_prev;

	// word decode: bit 0 of the address is ignored, lanes come from cfg_be
	assign control_hit = cfg_addr[7:1] == power_control_offset[7:1];
	assign mailbox_hit = cfg_addr[7:1] == mailbox_offset[7:1];

	// mailbox storage
	// scratch, flag and event bit share one word; each lane is written on its own
	assign mailbox_wr.wr = cfg_wr && mailbox_hit;
	assign mailbox_wr.be = cfg_be;
	assign mailbox_wr.wdata = cfg_wdata;

	byte_lane_word #(
		.reset_value(mailbox_reset)
	) mailbox_word (
		.mclk(mclk),
		.sys_rst(sys_rst),
		.wr_port(mailbox_wr),
		.value(mailbox_value)
	);

	// the event bit is only ever changed by a software write or by reset; no other hardware clears it
	assign mailbox_event = mailbox_value[mailbox_event_pos];
	assign smi_request = mailbox_event;
	assign software_flag = mailbox_value[mailbox_flag_msb:mailbox_flag_lsb];
	assign scratch_byte = mailbox_value[mailbox_scratch_msb:mailbox_scratch_lsb];

	// one pulse when the event bit goes from clear to set
	// reset clears the event bit as well, so leaving reset never looks like a new event
	always_ff @(posedge mclk)
	begin
		if (sys_rst)
		begin
			event_prev <= 1'b0;
		end
		else
		begin
			event_prev <= mailbox_event;
		end
	end

	always_ff @(posedge mclk)
	begin
		if (sys_rst)
		begin
			smi_trigger <= 1'b0;
		end
		else
		begin
			smi_trigger <= mailbox_event && !event_prev;
		end
	end

	// power state field: only the low byte lane carries it
	assign control_wr = cfg_wr && control_hit && cfg_be[0];
	assign requested_state = cfg_wdata[power_state_msb:power_state_lsb];

	// D1 and D2 are not built: such a write is still acked, its code is dropped
	always_comb
	begin
		unique case (power_state_type'(requested_state))
			state_d0: state_supported = 1'b1;
			state_d3: state_supported = 1'b1;
			state_d1: state_supported = 1'b0;
			state_d2: state_supported = 1'b0;
		endcase
	end

	always_comb
	begin
		next_power_state = power_state;
		if (control_wr && state_supported)
		begin
			next_power_state = requested_state;
		end
	end

	// a reset always lands in D0
	always_ff @(posedge mclk)
	begin
		if (sys_rst)
		begin
			power_state <= power_state_reset;
		end
		else
		begin
			power_state <= next_power_state;
		end
	end

	// optional controller reinitialisation when leaving D3 for D0
	// a single pulse, so the controller sees one request per wake-up
	always_ff @(posedge mclk)
	begin
		if (sys_rst)
		begin
			graphics_reinit <= 1'b0;
		end
		else
		begin
			graphics_reinit <= reinit_on_d0
				&& power_state == state_d3
				&& next_power_state == state_d0;
		end
	end

	// read view of the power control/status word
	// reserved bits and both wake bits read zero; writes to them land nowhere
	always_comb
	begin
		control_view = 16'h0000;
		control_view[wake_event_status_pos] = wake_event_status_value;
		control_view[wake_event_enable_pos] = wake_event_enable_value;
		control_view[power_state_msb:power_state_lsb] = power_state;
	end

	// read mux; unmapped offsets read as zero
	always_comb
	begin
		next_rdata = 16'h0000;
		if (control_hit)
		begin
			next_rdata = control_view;
		end
		else if (mailbox_hit)
		begin
			next_rdata = mailbox_value;
		end
		if (!cfg_be[0])
		begin
			next_rdata[7:0] = 8'h00;
		end
		if (!cfg_be[1])
		begin
			next_rdata[15:8] = 8'h00;
		end
	end

	always_ff @(posedge mclk)
	begin
		if (sys_rst)
		begin
			cfg_rdata <= 16'h0000;
		end
		else if (cfg_rd)
		begin
			// holds until the next read, so a slow master may take it late
			cfg_rdata <= next_rdata;
		end
	end

	// every access, including a discarded state write, completes normally
	always_ff @(posedge mclk)
	begin
		if (sys_rst)
		begin
			cfg_ack <= 1'b0;
		end
		else
		begin
			cfg_ack <= cfg_wr || cfg_rd;
		end
	end

endmodule

`default_nettype wire

// ===== gfx_pm_pkg.sv
package gfx_pm_pkg;

	// configuration byte offsets of this function
	localparam logic [7:0] power_control_offset = 8'hD4;
	localparam logic [7:0] mailbox_offset = 8'hE0;

	// power state control/status field layout
	localparam int wake_event_status_pos = 15;
	localparam int wake_event_enable_pos = 8;
	localparam int power_state_lsb = 0;
	localparam int power_state_msb = 1;

	// software interrupt mailbox field layout
	localparam int mailbox_event_pos = 0;
	localparam int mailbox_flag_lsb = 1;
	localparam int mailbox_flag_msb = 7;
	localparam int mailbox_scratch_lsb = 8;
	localparam int mailbox_scratch_msb = 15;

	// reset values
	localparam logic [15:0] mailbox_reset = 16'h0000;
	localparam logic [1:0] power_state_reset = 2'h0;
	localparam logic wake_event_status_value = 1'h0;
	localparam logic wake_event_enable_value = 1'h0;

	// access answer latency in clock cycles
	localparam int access_latency = 1;

	typedef enum logic [1:0]
	{
		state_d0 = 2'h0,
		state_d1 = 2'h1,
		state_d2 = 2'h2,
		state_d3 = 2'h3
	} power_state_type;

endpackage

// ===== word_write_if.sv
`timescale 1ns/1ps
`default_nettype none

interface word_write_if;
	logic wr;
	logic [1:0] be;
	logic [15:0] wdata;

	modport source
	(
		output wr,
		output be,
		output wdata
	);

	modport sink
	(
		input wr,
		input be,
		input wdata
	);
endinterface

`default_nettype wire

// ===== byte_lane_word.sv
`timescale 1ns/1ps
`default_nettype none

// 16-bit storage word with per-byte write enables
module byte_lane_word
	import gfx_pm_pkg::*;
#(
	parameter logic [15:0] reset_value = 16'h0000
)
(
	// clock and reset
	input wire logic mclk,
	input wire logic sys_rst,
	// write side
	word_write_if.sink wr_port,
	// stored value
	output logic [15:0] value
);

	always_ff @(posedge mclk)
	begin
		if (sys_rst)
		begin
			value <= reset_value;
		end
		else if (wr_port.wr)
		begin
			if (wr_port.be[0])
			begin
				value[7:0] <= wr_port.wdata[7:0];
			end
			if (wr_port.be[1])
			begin
				value[15:8] <= wr_port.wdata[15:8];
			end
		end
	end

endmodule

`default_nettype wire

// ===== gfx_regs_asserts.sv
`timescale 1ns/1ps
`default_nettype none

module gfx_chk
	import gfx_pm_pkg::*;
(
	// all ports of the register block
	input wire logic mclk,
	input wire logic sys_rst,
	input wire logic [7:0] cfg_addr,
	input wire logic cfg_wr,
	input wire logic cfg_rd,
	input wire logic [1:0] cfg_be,
	input wire logic [15:0] cfg_wdata,
	input wire logic [15:0] cfg_rdata,
	input wire logic cfg_ack,
	input wire logic [1:0] power_state,
	input wire logic graphics_reinit,
	input wire logic smi_request,
	input wire logic smi_trigger,
	input wire logic [6:0] software_flag,
	input wire logic [7:0] scratch_byte
);
	default clocking @(posedge mclk);
	endclocking
	default disable iff (sys_rst);
	wire pm_hit = cfg_addr[7:1] == power_control_offset[7:1];
	wire pm_wr = cfg_wr && pm_hit;
	wire pm_rd = cfg_rd && pm_hit;
	wire state_wr = pm_wr && cfg_be[0];
	wire mb_wr = cfg_wr && cfg_addr[7:1] == mailbox_offset[7:1];
	a_ack_each: assert property ((cfg_wr || cfg_rd) |=> cfg_ack)
		else $error("access not acknowledged");
	a_state_legal: assert property (power_state != 2'h1 && power_state != 2'h2)
		else $error("unsupported power state");
	a_bad_kept: assert property (pm_wr && cfg_be[0] && ^cfg_wdata[1:0] |=> $stable(power_state))
		else $error("bad state code taken");
	a_good_taken: assert property (state_wr && !(^cfg_wdata[1:0]) |=> power_state == $past(cfg_wdata[1:0]))
		else $error("state write lost");
	a_wake_zero: assert property (pm_rd |=> !cfg_rdata[15] && !cfg_rdata[8])
		else $error("wake bits read one");
	a_smi_set: assert property (mb_wr && cfg_be[0] && cfg_wdata[0] |=> smi_request)
		else $error("event not raised");
	a_smi_kept: assert property (!(mb_wr && cfg_be[0]) |=> $stable(smi_request))
		else $error("event changed alone");
	a_flag_taken: assert property (mb_wr && cfg_be[0] |=> software_flag == $past(cfg_wdata[7:1]))
		else $error("flag write lost");
	a_event_pulse: assert property ($rose(smi_request) |=> smi_trigger)
		else $error("event pulse missing");
	a_pulse_cause: assert property (smi_trigger |-> $past(smi_request) && !$past(smi_request, 2))
		else $error("event pulse without a new event");
	a_reinit_pulse: assert property (graphics_reinit == ($past(power_state) == 2'h3 && power_state == 2'h0))
		else $error("reinit pulse wrong");
	cover property (pm_wr && cfg_be[0] && cfg_wdata[1:0] == 2'h3);
	cover property (state_wr && ^cfg_wdata[1:0]);
	cover property ($rose(smi_request) ##1 smi_trigger);
	cover property (graphics_reinit);
endmodule

bind gfx_power_state_and_sw_smi_regs gfx_chk i_chk (.mclk, .sys_rst, .cfg_addr, .cfg_wr, .cfg_rd, .cfg_be,
	.cfg_wdata, .cfg_rdata, .cfg_ack, .power_state, .graphics_reinit, .smi_request, .smi_trigger,
	.software_flag, .scratch_byte);

`default_nettype wire

// ===== gfx_power_state_and_sw_smi_regs_bench.sv
`timescale 1ns/1ps
`default_nettype none

module gfx_power_state_and_sw_smi_regs_bench
	import gfx_pm_pkg::*;
;
	logic mclk = 0;
	logic sys_rst = 1;
	logic cfg_wr = 0;
	logic cfg_rd = 0;
	logic cfg_ack, graphics_reinit, smi_request, smi_trigger;
	logic [7:0] cfg_addr = 8'h00;
	logic [1:0] cfg_be = 2'h0;
	logic [1:0] power_state;
	logic [1:0] ps = 2'h0;
	logic [15:0] cfg_wdata = 16'h0000;
	logic [15:0] cfg_rdata;
	logic [15:0] mb = 16'h0000;
	logic [6:0] software_flag;
	logic [7:0] scratch_byte;
	logic [31:0] x;
	logic [7:0] adr [4] = '{power_control_offset, mailbox_offset, 8'hE2, 8'h10};
	int n_mismatch = 0;
	int checked = 0;
	int seed = 32'h7094CD94;

	gfx_power_state_and_sw_smi_regs i_dut (.mclk, .sys_rst, .cfg_addr, .cfg_wr, .cfg_rd, .cfg_be, .cfg_wdata,
		.cfg_rdata, .cfg_ack, .power_state, .graphics_reinit, .smi_request, .smi_trigger, .software_flag,
		.scratch_byte);

	always #2.5 mclk = ~mclk;

	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		checked++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("unexpected at %0t: %h vs %h", $time, seen, exp);
		end
	endtask

	task automatic wrap_up;
		if (n_mismatch == 0 && checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// one access, then an idle cycle to see the delayed event pulse
	task automatic acc(input logic w, input logic [7:0] a, input logic [1:0] b, input logic [15:0] d);
		logic [15:0] m, r;
		logic rise, back;
		m = {{8{b[1]}}, {8{b[0]}}};
		r = a == power_control_offset ? {14'h0, ps} & m : a == mailbox_offset ? mb & m : 16'h0000;
		rise = 0;
		back = 0;
		if (w && a == power_control_offset && b[0] && d[1:0] != 2'h1 && d[1:0] != 2'h2)
		begin
			back = ps == 2'h3 && d[1:0] == 2'h0;
			ps = d[1:0];
		end
		if (w && a == mailbox_offset)
		begin
			rise = b[0] && d[0] && !mb[0];
			mb = mb & ~m | d & m;
		end
		cfg_wr = w;
		cfg_rd = !w;
		cfg_addr = a;
		cfg_be = b;
		cfg_wdata = d;
		@(negedge mclk);
		cfg_wr = 0;
		cfg_rd = 0;
		chk(cfg_ack, 1);
		if (!w)
			chk(cfg_rdata, r);
		chk(power_state, ps);
		chk(graphics_reinit, back);
		chk({smi_request, software_flag, scratch_byte}, {mb[0], mb[7:1], mb[15:8]});
		@(negedge mclk);
		chk(smi_trigger, rise);
		chk(cfg_ack, 0);
	endtask

	initial
	begin
		repeat (20) @(negedge mclk);
		sys_rst = 0;
		acc(0, power_control_offset, 2'h3, 16'h0000);
		acc(0, mailbox_offset, 2'h3, 16'h0000);
		// codes 3,2,1,0 with the wake bits set in the written word
		for (int c = 3; c >= 0; c--)
		begin
			acc(1, power_control_offset, 2'h3, 16'hFFFC | 16'(c));
			acc(0, power_control_offset, 2'h3, 16'h0000);
		end
		acc(1, mailbox_offset, 2'h3, 16'h5A01);
		acc(1, mailbox_offset, 2'h2, 16'h0000);
		acc(1, mailbox_offset, 2'h1, 16'h0000);
		repeat (400)
		begin
			x = $random(seed);
			acc(x[31], adr[x[29:28]], x[17:16], x[15:0]);
		end
		// reset in mid-run from D3 with the event bit set
		acc(1, power_control_offset, 2'h1, 16'h0003);
		acc(1, mailbox_offset, 2'h3, 16'hA5FF);
		sys_rst = 1;
		repeat (3) @(negedge mclk);
		sys_rst = 0;
		ps = 2'h0;
		mb = 16'h0000;
		acc(0, power_control_offset, 2'h3, 16'h0000);
		acc(0, mailbox_offset, 2'h3, 16'h0000);
		wrap_up();
	end
endmodule

`default_nettype wire
